/* File: bench/dsc_host_model.sv */
`timescale 1ns/1ns
module dsc_host_model (
	input wire logic go, // Start one frame.
	input wire logic [15:0] word, // Word to shift out.
	output logic sclk, // Serial clock, idles high.
	output logic serial_data_in, // Serial data, MSB first.
	output logic frame_sync_n, // Frame, active low.
	output logic busy // Frame in progress.
);
	initial begin
		sclk = 1'b1;
		serial_data_in = 1'b0;
		frame_sync_n = 1'b1;
		busy = 1'b0;
	end
	// The clock stands high between frames and only runs while a word is sent.
	always begin
		wait (go === 1'b1);
		busy = 1'b1;
		#37 frame_sync_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			serial_data_in = word[i];
			#80 sclk = 1'b0;
			#80 sclk = 1'b1;
		end
		#40 frame_sync_n = 1'b1;
		// A released data line shows the inverse, so a stale bit never passes for data.
		serial_data_in = ~serial_data_in;
		wait (go === 1'b0);
		busy = 1'b0;
	end
endmodule : dsc_host_model

/* File: bench/dsc_serial_decoder_bench.sv */
`timescale 1ns/1ns
module dsc_serial_decoder_bench
	import dsc_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready, pslverr, sclk, sdi, fsn, busy, e;
	logic go = 1'b0;
	logic [15:0] word = '0;
	logic [2:0] pins = RST_SEL_PINS;
	logic [1:0][31:0] tuning_word_reg;
	logic [3:0][PHASE_W-1:0] phase_offset;
	logic freq_sel_out, power_down, reference_output_en, acc_zero;
	logic [1:0] phase_sel_out;
	logic [31:0] q;
	int fail_count = 0;
	int checks_done = 0;
	int la, ls;
	always #5 pclk = ~pclk;
	dsc_serial_decoder dsc_serial_decoder_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sclk(sclk), .serial_data_in(sdi), .frame_sync_n(fsn),
		.tuning_word_reg_choice(pins[2]), .phase_choice_lo(pins[0]), .phase_choice_hi(pins[1]),
		.tuning_word_reg(tuning_word_reg), .phase_offset(phase_offset), .freq_sel_out(freq_sel_out),
		.phase_sel_out(phase_sel_out), .power_down(power_down), .reference_output_en(reference_output_en),
		.acc_zero(acc_zero));
	dsc_host_model dsc_host_model_i (.go(go), .word(word), .sclk(sclk), .serial_data_in(sdi),
		.frame_sync_n(fsn), .busy(busy));
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			fail_count++;
			final_report();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Moves the select pins and counts edges until both selection outputs show them.
	task automatic pin_lat(input logic [2:0] p, output int lat);
		lat = 0;
		@(posedge pclk);
		pins <= p;
		do begin
			@(posedge pclk);
			lat++;
		end while ({freq_sel_out, phase_sel_out} !== p && lat < 50);
		if (lat >= 50) begin
			fail_count++;
			final_report();
		end
	endtask : pin_lat
	// A command word goes in through the register port; the wait covers the synchronised path.
	// The bench never sends the reserved test code.
	task automatic cmd(input logic [15:0] w);
		apb(1'b1, REG_CMD, {16'h0, w});
		repeat (8) @(posedge pclk);
	endtask : cmd
	// Sends one serial frame and measures edges from the completion stall to a frequency change.
	task automatic ser(input logic [15:0] w, output int lat);
		logic [1:0][31:0] old;
		int n, td, tc;
		logic started;
		old = tuning_word_reg;
		n = 0;
		td = -1;
		tc = -1;
		started = 1'b0;
		@(posedge pclk);
		go <= 1'b1;
		word <= w;
		while (n < 2000 && !(started && busy === 1'b0 && td > 0 && n > td + 6)) begin
			@(posedge pclk);
			n++;
			if (busy === 1'b1) begin
				started = 1'b1;
				go <= 1'b0;
			end
			if (pready === 1'b0 && td < 0) td = n;
			if (tuning_word_reg !== old && tc < 0) tc = n;
		end
		if (n >= 2000) begin
			fail_count++;
			final_report();
		end
		lat = (tc < 0) ? -99 : tc - td;
	endtask : ser
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		check(tuning_word_reg[0] | tuning_word_reg[1], 32'h0);
		check({power_down, reference_output_en, acc_zero, freq_sel_out, phase_sel_out}, 32'h10);
		apb(1'b0, 12'h040, 32'h0);
		check({31'h0, e}, 32'h1);
		check(q, 32'h0);
		apb(1'b1, REG_FREQ0, 32'hffffffff);
		apb(1'b0, REG_FREQ0, 32'h0);
		check(q, 32'h0);
		$display("test reset and map done");
		ser(16'h31ab, la);
		check(tuning_word_reg[0], 32'h0);
		ser(16'h20cd, la);
		check(tuning_word_reg[0], 32'h0000abcd);
		check(la, 32'd1);
		ser(16'ha000, ls);
		ser(16'h3712, ls);
		ser(16'h2634, ls);
		check(tuning_word_reg[1], 32'h12340000);
		check(ls - la, 32'd2);
		apb(1'b0, REG_FREQ1, 32'h0);
		check(q, 32'h12340000);
		$display("test frequency loads done");
		// High phase bytes keep their top nibble zero.
		for (int i = 0; i < 4; i++) begin
			cmd({CMD_PH_DEFER, 4'(9 + 2 * i), 8'(12 - i)});
			cmd({CMD_PH_DIRECT, 4'(8 + 2 * i), 8'(8'h5a + i)});
			check(32'(phase_offset[i]), {20'h0, 4'(12 - i), 8'(8'h5a + i)});
			apb(1'b0, REG_PHASE0 + 12'(4 * i), 32'h0);
			check(q, {20'h0, 4'(12 - i), 8'(8'h5a + i)});
		end
		cmd({CMD_PH_DEFER, 4'h8, 8'hff});
		check(32'(phase_offset[0]), 32'h00000c5a);
		$display("test phase loads done");
		pins <= 3'h6;
		cmd(16'h8fff);
		apb(1'b0, REG_STATUS, 32'h0);
		check(q & 32'h3, 32'h0);
		check({29'h0, freq_sel_out, phase_sel_out}, 32'h6);
		cmd(16'h9000);
		pins <= 3'h3;
		cmd(16'h6c00);
		check({29'h0, freq_sel_out, phase_sel_out}, 32'h6);
		cmd(16'h4200);
		check({29'h0, freq_sel_out, phase_sel_out}, 32'h5);
		cmd(16'h5000);
		check({29'h0, freq_sel_out, phase_sel_out}, 32'h1);
		$display("test selection done");
		cmd(16'he7ff);
		check({29'h0, power_down, reference_output_en, acc_zero}, 32'h4);
		apb(1'b0, REG_STATUS, 32'h0);
		check(q & 32'hf, 32'h6);
		cmd(16'hd800);
		check({29'h0, power_down, reference_output_en, acc_zero}, 32'h3);
		apb(1'b0, REG_STATUS, 32'h0);
		check(q & 32'hf, 32'h8);
		check({29'h0, freq_sel_out, phase_sel_out}, 32'h3);
		cmd(16'hb000);
		repeat (20) @(posedge pclk);
		apb(1'b0, REG_STATUS, 32'h0);
		check(q & 32'h3, 32'h3);
		check((q >> 10) & 32'h1, 32'h0);
		$display("test sleep reset clear done");
		cmd(16'h8000);
		pin_lat(3'h5, la);
		check({29'h0, freq_sel_out, phase_sel_out}, 32'h5);
		cmd(16'ha000);
		pin_lat(3'h2, ls);
		check({29'h0, freq_sel_out, phase_sel_out}, 32'h2);
		check(ls - la, 32'd2);
		$display("test pin alignment done");
		final_report();
	end
endmodule : dsc_serial_decoder_bench

/* File: pkg/dsc_pkg.sv */
package dsc_pkg;
	localparam int WORD_W = 16;
	localparam int BYTE_W = 8;
	localparam int HALF_W = 16;
	localparam int PHASE_W = 12;
	localparam int APB_AW = 12;
	localparam logic [4:0] BIT_LAST = 5'h0f;
	localparam logic [3:0] CMD_PH_DIRECT = 4'h0;
	localparam logic [3:0] CMD_PH_DEFER = 4'h1;
	localparam logic [3:0] CMD_FR_DIRECT = 4'h2;
	localparam logic [3:0] CMD_FR_DEFER = 4'h3;
	localparam logic [3:0] CMD_PSEL = 4'h4;
	localparam logic [3:0] CMD_FSEL = 4'h5;
	localparam logic [3:0] CMD_BOTHSEL = 4'h6;
	localparam logic [3:0] CMD_TEST = 4'h7;
	localparam logic [1:0] TOP_SRCSYNC = 2'h2;
	localparam logic [1:0] TOP_SLEEP = 2'h3;
	localparam int POS_TOP = 14;
	localparam int POS_CMD = 12;
	localparam int POS_ADDR = 8;
	localparam int POS_SYNC = 13;
	localparam int POS_CHOICE_SOURCE_BIT = 12;
	localparam int POS_SLEEP = 13;
	localparam int POS_ACCRST = 12;
	localparam int POS_WIPE = 11;
	localparam int POS_FSEL = 11;
	localparam int POS_PSEL = 9;
	localparam int ADDR_PHASE = 3;
	localparam int ADDR_FREG = 2;
	localparam int ADDR_HALF = 1;
	localparam int ADDR_BYTE = 0;
	localparam logic [APB_AW-1:0] REG_STATUS = 12'h000;
	localparam logic [APB_AW-1:0] REG_CMD = 12'h004;
	localparam logic [APB_AW-1:0] REG_FREQ0 = 12'h008;
	localparam logic [APB_AW-1:0] REG_FREQ1 = 12'h00c;
	localparam logic [APB_AW-1:0] REG_PHASE0 = 12'h010;
	localparam logic [HALF_W-1:0] RST_HALF = 16'h0000;
	localparam logic [PHASE_W-1:0] RST_PHASE = 12'h000;
	localparam logic [2:0] RST_SERIAL_PINS = 3'h6;
	localparam logic [2:0] RST_SEL_PINS = 3'h0;
	typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_DONE} dsc_rx_state_t;
endpackage : dsc_pkg

/* File: rtl/dsc_serial_decoder.sv */
`timescale 1ns/1ns
// Summary of operation
// - Code 0000 merges byte, writes phase register.
// - Code 0001 loads defer half only.
// - Code 0010 merges byte, writes frequency half.
// - Code 0011 loads defer half only.
// - Code 0100 latches D10..D9 phase select bits.
// - Code 0101 latches D11 frequency select bit.
// - Code 0110 latches both selects together.
// - Top bits 10 mean source/sync command.
// - D13 sets the synchronisation bit.
// - Synchronisation adds two master clock cycles.
// - Without synchronisation, apply without extra stage.
// - D12 picks bits or pins as select source.
// - Top 11 command, D13 powers down.
// - D12 forces phase accumulator to zero.
// - D11 clears sync and select source.
// - Clear bit returns low by itself.
// - Word is command, address, data byte.
// - Source/sync command ignores D11..D0.
// - Sleep command ignores D10..D0.
// - Address picks frequency byte or phase byte.
// - Sixteen falling edges framed by sync low.
// - Direct transfer lands on next clock edge.
module dsc_serial_decoder
	import dsc_pkg::*;
(
	input wire logic pclk, // Master clock, 100 MHz.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic [APB_AW-1:0] paddr, // APB byte address.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB direction, high for write.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error for unmapped address.
	input wire logic sclk, // Serial clock from the host.
	input wire logic serial_data_in, // Serial data, MSB first.
	input wire logic frame_sync_n, // Frame sync, active low.
	input wire logic tuning_word_reg_choice, // Frequency select pin.
	input wire logic phase_choice_lo, // Phase select pin, low bit.
	input wire logic phase_choice_hi, // Phase select pin, high bit.
	output logic [1:0][31:0] tuning_word_reg, // Frequency registers 1 and 0.
	output logic [3:0][PHASE_W-1:0] phase_offset, // Phase offset registers 3..0.
	output logic freq_sel_out, // Frequency register in use.
	output logic [1:0] phase_sel_out, // Phase register in use.
	output logic power_down, // Sleep, clocks and DAC off.
	output logic reference_output_en, // Reference output enabled.
	output logic acc_zero // Hold phase accumulator at zero.
);
	logic sclk_s;
	logic fsn_s;
	logic sdi_s;
	logic sclk_d_r;
	logic [2:0] sel_pin_s;
	logic [2:0] sel_pin_d;
	dsc_rx_state_t rx_state_r;
	dsc_rx_state_t rx_state_nxt;
	logic [4:0] bitcnt_r;
	logic [4:0] bitcnt_nxt;
	logic [WORD_W-1:0] shift_r;
	logic [WORD_W-1:0] shift_nxt;
	logic [HALF_W-1:0] defer_r;
	logic [HALF_W-1:0] defer_nxt;
	logic [1:0][1:0][HALF_W-1:0] tuning_r;
	logic [3:0][PHASE_W-1:0] phase_r;
	logic sync_r;
	logic sync_nxt;
	logic choice_source_bit_r;
	logic choice_source_bit_nxt;
	logic sleep_r;
	logic sleep_nxt;
	logic accrst_r;
	logic accrst_nxt;
	logic wipe_r;
	logic wipe_nxt;
	logic fsel_bit_r;
	logic fsel_bit_nxt;
	logic [1:0] psel_bits_r;
	logic [1:0] psel_bits_nxt;
	logic test_seen_r;
	logic freq_sel_r;
	logic [1:0] phase_sel_r;
	logic [31:0] prdata_r;
	logic dly_valid;
	logic [WORD_W-1:0] dly_word;

	dsc_sync2 #(.W(3), .RST(RST_SERIAL_PINS)) u_pin_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({sclk, frame_sync_n, serial_data_in}),
		.q({sclk_s, fsn_s, sdi_s})
	);

	dsc_sync2 #(.W(3), .RST(RST_SEL_PINS)) u_sel_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({tuning_word_reg_choice, phase_choice_hi, phase_choice_lo}),
		.q(sel_pin_s)
	);

	// Pin samples take two more master clock edges while synchronisation is on.
	dsc_sync2 #(.W(3), .RST(RST_SEL_PINS)) u_sel_dly (
		.clk(pclk),
		.rst_n(presetn),
		.d(sel_pin_s),
		.q(sel_pin_d)
	);

	// Serial receiver.
	wire sclk_fall = sclk_d_r && !sclk_s;
	wire take_bit = !fsn_s && sclk_fall && (rx_state_r != RX_DONE);
	wire ser_done = take_bit && (bitcnt_r == BIT_LAST);
	wire [WORD_W-1:0] ser_word = {shift_r[WORD_W-2:0], sdi_s};
	assign shift_nxt = take_bit ? ser_word : shift_r;
	assign bitcnt_nxt = fsn_s ? 5'h00 : (take_bit ? 5'(bitcnt_r + 5'h01) : bitcnt_r);

	// Edges past the sixteenth are ignored until the frame closes.
	always_comb begin
		rx_state_nxt = rx_state_r;
		unique case (rx_state_r)
			RX_IDLE: begin
				if (!fsn_s) rx_state_nxt = RX_SHIFT;
			end
			RX_SHIFT: begin
				if (fsn_s) rx_state_nxt = RX_IDLE;
				else if (ser_done) rx_state_nxt = RX_DONE;
			end
			RX_DONE: begin
				if (fsn_s) rx_state_nxt = RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_d_r <= 1'b1;
			rx_state_r <= RX_IDLE;
			bitcnt_r <= 5'h00;
			shift_r <= 16'h0000;
		end else begin
			sclk_d_r <= sclk_s;
			rx_state_r <= rx_state_nxt;
			bitcnt_r <= bitcnt_nxt;
			shift_r <= shift_nxt;
		end
	end

	// APB slave; the command register injects a word as if it came serially.
	wire apb_setup = psel && !penable;
	wire apb_access = psel && penable;
	wire hit_status = (paddr == REG_STATUS);
	wire hit_cmd = (paddr == REG_CMD);
	wire hit_freq0 = (paddr == REG_FREQ0);
	wire hit_freq1 = (paddr == REG_FREQ1);
	wire hit_phase = (paddr[APB_AW-1:4] == REG_PHASE0[APB_AW-1:4]) && (paddr[1:0] == 2'h0);
	wire addr_hit = hit_status || hit_cmd || hit_freq0 || hit_freq1 || hit_phase;
	// A serial word owns the decoder in its cycle, so APB waits one cycle then.
	assign pready = !ser_done;
	assign pslverr = apb_access && !addr_hit;
	wire apb_cmd_wr = apb_access && pwrite && hit_cmd && pready;
	wire [31:0] status_word = {11'h000, bitcnt_r, 5'h00, test_seen_r, phase_sel_r, freq_sel_r,
		psel_bits_r, fsel_bit_r, accrst_r, sleep_r, choice_source_bit_r, sync_r};
	wire [31:0] rd_mux = hit_status ? status_word :
		hit_freq0 ? tuning_r[0] :
		hit_freq1 ? tuning_r[1] :
		hit_phase ? {20'h00000, phase_r[paddr[3:2]]} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) prdata_r <= 32'h00000000;
		else if (apb_setup && !pwrite) prdata_r <= rd_mux;
	end
	assign prdata = prdata_r;

	// Command source and the optional two-edge alignment stage.
	wire cmd_valid = ser_done || apb_cmd_wr;
	wire [WORD_W-1:0] cmd_word = ser_done ? ser_word : pwdata[WORD_W-1:0];

	dsc_sync2 #(.W(WORD_W + 1), .RST(17'h00000)) u_cmd_dly (
		.clk(pclk),
		.rst_n(presetn),
		.d({cmd_valid && sync_r, cmd_word}),
		.q({dly_valid, dly_word})
	);

	// Serial words are sixteen serial bits apart, but APB words two edges apart can meet a delayed word; the delayed word wins.
	wire apply_valid = dly_valid || (cmd_valid && !sync_r);
	wire [WORD_W-1:0] aw = dly_valid ? dly_word : cmd_word;
	wire [1:0] top = aw[POS_TOP +: 2];
	wire [3:0] cmd = aw[POS_CMD +: 4];
	wire [3:0] addr = aw[POS_ADDR +: 4];
	wire [BYTE_W-1:0] dbyte = aw[BYTE_W-1:0];
	wire is_reg = apply_valid && !aw[WORD_W-1];
	wire do_srcsync = apply_valid && (top == TOP_SRCSYNC);
	wire do_sleep = apply_valid && (top == TOP_SLEEP);
	wire do_defer = is_reg && (cmd[3:2] == 2'h0);
	wire ph_direct = is_reg && (cmd == CMD_PH_DIRECT) && addr[ADDR_PHASE];
	wire fr_direct = is_reg && (cmd == CMD_FR_DIRECT) && !addr[ADDR_PHASE];
	wire ph_defer = is_reg && (cmd == CMD_PH_DEFER);
	wire fr_defer = is_reg && (cmd == CMD_FR_DEFER);
	wire set_psel = is_reg && ((cmd == CMD_PSEL) || (cmd == CMD_BOTHSEL));
	wire set_fsel = is_reg && ((cmd == CMD_FSEL) || (cmd == CMD_BOTHSEL));
	wire [1:0] ph_idx = addr[2:1];
	wire fr_idx = addr[ADDR_FREG];
	wire fr_half = addr[ADDR_HALF];
	wire [1:0] word_psel = aw[POS_PSEL +: 2];
	wire word_fsel = aw[POS_FSEL];

	// The byte lands in its defer half; direct codes take the merged word.
	assign defer_nxt = !do_defer ? defer_r :
		(addr[ADDR_BYTE] ? {dbyte, defer_r[BYTE_W-1:0]} : {defer_r[HALF_W-1:BYTE_W], dbyte});
	// Only the low twelve bits are kept; the host zeroes the top nibble.
	wire [PHASE_W-1:0] merged_phase = defer_nxt[PHASE_W-1:0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			defer_r <= RST_HALF;
			tuning_r <= {4{RST_HALF}};
			phase_r <= {4{RST_PHASE}};
		end else begin
			defer_r <= defer_nxt;
			if (ph_direct) phase_r[ph_idx] <= merged_phase;
			if (fr_direct) tuning_r[fr_idx][fr_half] <= defer_nxt;
		end
	end
	assign tuning_word_reg = tuning_r;
	assign phase_offset = phase_r;

	// Control bits; bits outside each command's fields are never looked at.
	assign sync_nxt = do_srcsync ? aw[POS_SYNC] : (wipe_r ? 1'b0 : sync_r);
	assign choice_source_bit_nxt = do_srcsync ? aw[POS_CHOICE_SOURCE_BIT] : (wipe_r ? 1'b0 : choice_source_bit_r);
	assign sleep_nxt = do_sleep ? aw[POS_SLEEP] : sleep_r;
	assign accrst_nxt = do_sleep ? aw[POS_ACCRST] : accrst_r;
	assign wipe_nxt = do_sleep && aw[POS_WIPE];
	assign psel_bits_nxt = set_psel ? word_psel : psel_bits_r;
	assign fsel_bit_nxt = set_fsel ? word_fsel : fsel_bit_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_r <= 1'b0;
			choice_source_bit_r <= 1'b0;
			sleep_r <= 1'b0;
			accrst_r <= 1'b0;
			wipe_r <= 1'b0;
			psel_bits_r <= 2'h0;
			fsel_bit_r <= 1'b0;
			test_seen_r <= 1'b0;
		end else begin
			sync_r <= sync_nxt;
			choice_source_bit_r <= choice_source_bit_nxt;
			sleep_r <= sleep_nxt;
			accrst_r <= accrst_nxt;
			wipe_r <= wipe_nxt;
			psel_bits_r <= psel_bits_nxt;
			fsel_bit_r <= fsel_bit_nxt;
			// The reserved code only leaves a sticky trace in status.
			if (is_reg && (cmd == CMD_TEST)) test_seen_r <= 1'b1;
		end
	end

	// Select source: latched bits, or pins with the extra stage when aligned.
	wire [2:0] pin_pick = sync_r ? sel_pin_d : sel_pin_s;
	wire freq_sel_nxt = choice_source_bit_r ? fsel_bit_r : pin_pick[2];
	wire [1:0] phase_sel_nxt = choice_source_bit_r ? psel_bits_r : pin_pick[1:0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_sel_r <= 1'b0;
			phase_sel_r <= 2'h0;
		end else begin
			freq_sel_r <= freq_sel_nxt;
			phase_sel_r <= phase_sel_nxt;
		end
	end
	assign freq_sel_out = freq_sel_r;
	assign phase_sel_out = phase_sel_r;
	assign power_down = sleep_r;
	assign reference_output_en = !sleep_r;
	assign acc_zero = accrst_r;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_frame_length: assert property (ser_done |-> !fsn_s && bitcnt_r == 5'h0f && rx_state_r == RX_SHIFT)
		else $error("word completed at wrong bit count");
	a_phase_direct: assert property (ph_direct |=> phase_r[$past(ph_idx)] == $past(merged_phase))
		else $error("phase register not loaded from merged defer word");
	a_phase_defer: assert property (ph_defer |=> $stable(phase_r) && defer_r == $past(defer_nxt))
		else $error("phase defer write touched a phase register");
	a_freq_direct: assert property (fr_direct |=> tuning_r[$past(fr_idx)][$past(fr_half)] == $past(defer_nxt))
		else $error("frequency half not loaded from merged defer word");
	a_freq_defer: assert property (fr_defer |=> $stable(tuning_r))
		else $error("frequency defer write touched a frequency register");
	a_psel_latch: assert property (set_psel |=> psel_bits_r == $past(word_psel))
		else $error("phase select bits not latched");
	a_fsel_latch: assert property (set_fsel |=> fsel_bit_r == $past(word_fsel))
		else $error("frequency select bit not latched");
	a_sync_delay: assert property (cmd_valid && sync_r |-> ##2 dly_valid && dly_word == $past(cmd_word, 2))
		else $error("aligned word not applied two cycles later");
	a_async_path: assert property (cmd_valid && !sync_r |-> apply_valid && !dly_valid)
		else $error("unaligned word not applied at once");
	a_srcsync_set: assert property (do_srcsync |=> sync_r == $past(aw[POS_SYNC]) && choice_source_bit_r == $past(aw[POS_CHOICE_SOURCE_BIT]))
		else $error("sync or select source not set");
	a_wipe_clears: assert property (wipe_r && !do_srcsync |=> !sync_r && !choice_source_bit_r && !wipe_r)
		else $error("clear did not drop sync and select source");
	a_bits_steer: assert property (choice_source_bit_r && $stable(fsel_bit_r) |=> freq_sel_out == $past(fsel_bit_r))
		else $error("select bit not steering frequency choice");
	a_sleep_ref: assert property (do_sleep |=> power_down == $past(aw[POS_SLEEP]) && reference_output_en == !power_down)
		else $error("sleep bit not reflected on outputs");

	c_serial_word: cover property (ser_done);
	c_phase_load: cover property (fr_direct ##[1:1000] ph_direct);
	c_aligned: cover property (dly_valid);
	c_wipe: cover property (wipe_r);
endmodule : dsc_serial_decoder

/* File: rtl/dsc_sync2.sv */
`timescale 1ns/1ns
module dsc_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clk, // Sampling clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [W-1:0] d, // Data to pass through two stages.
	output logic [W-1:0] q // Data two edges later.
);
	logic [W-1:0] meta_r;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= RST;
			q <= RST;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : dsc_sync2
